// ===== logic/capture_tuning_config_regs.sv
// Module: capture front-end tuning and gain matching configuration registers on AHB-Lite
// Functional notes
// RULE_01: Software writes the first tuning register with 0xe8; it reads back what was written.
// RULE_02: Software writes the second tuning register with 0xe0; it reads back what was written.
// RULE_03: With the filter enable bit set, green sync pulses under 250 ns do not reach the clock loop; it resets to 0.
// RULE_04: Gear select 0 gives the normal oscillator range, 1 selects the lower range.
// RULE_05: Software keeps the upper four bits of the gain control register at zero.
// RULE_06: With the hold bit at 1, gains update on every update interval.
// RULE_07: With the hold bit at 0, updates stop and the last gains are kept.
// RULE_08: The hold bit reads 0 after reset.
// RULE_09: Enable field 000 disables gain matching and 110 enables it.
// RULE_10: One-time calibration is enable, set hold, wait to settle, then clear hold.
// RULE_11: Gains reach their final values within ten updates once updates begin.
// RULE_12: A one-time calibration is repeated after power-up and each mode change.
// RULE_13: Continuous updating is recommended to follow drift.
// RULE_14: The update interval is a programmable count of horizontal syncs, one update per expiry.
//
// Decided for this implementation: the AHB-Lite register port.
module capture_tuning_config_regs (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        green_channel_sync,
   input  wire logic        hsync_in,
   input  wire logic [7:0]  gain_target,
   output logic             green_sync_out,
   output logic             oscillator_low_range_sel,
   output logic             green_sync_pulse_filter_en,
   output logic [7:0]       gain_value
);

   // ==========================================================
   // Register storage
   logic [7:0]  tuning_a_q,   tuning_a_d;
   logic [7:0]  tuning_b_q,   tuning_b_d;
   logic [7:0]  filt_ctrl_q,  filt_ctrl_d;
   logic [7:0]  gear_ctrl_q,  gear_ctrl_d;
   logic [7:0]  gain_ctrl_q,  gain_ctrl_d;
   logic [7:0]  interval_q,   interval_d;
   logic        wr_pend_q,    wr_pend_d;
   logic [7:0]  wr_addr_q,    wr_addr_d;
   logic [31:0] hrdata_q,     hrdata_d;
   logic        gear_out_q,   gear_out_d;
   logic        filt_out_q,   filt_out_d;
   logic [7:0]  gain_out_q,   gain_out_d;

   // Pin synchronisers and sync filter state
   logic        gs_meta_q, gs_sync_q, gs_prev_q;
   logic        hs_meta_q, hs_sync_q, hs_prev_q;
   logic [3:0]  pulse_cnt_q,  pulse_cnt_d;
   logic        gs_out_q,     gs_out_d;

   gain_ctrl_if gctl ();

   // Register index decode: the word index is haddr[9:2]
   // Each register owns one aligned word; the low and upper address bits are ignored
   // Unmapped indices read as zero and swallow writes
   function automatic logic [31:0] read_mux(input logic [7:0] a, input logic [7:0] ta, input logic [7:0] tb,
                                            input logic [7:0] fc, input logic [7:0] gc, input logic [7:0] ac,
                                            input logic [7:0] iv, input logic [7:0] st, input logic [7:0] gv);
      read_mux = 32'h0000_0000;
      case (a)
         capture_tuning_pkg::IDX_TUNING_A:      read_mux = {24'h00_0000, ta}; // RULE_01
         capture_tuning_pkg::IDX_TUNING_B:      read_mux = {24'h00_0000, tb}; // RULE_02
         capture_tuning_pkg::IDX_SYNC_FILTER:   read_mux = {24'h00_0000, fc};
         capture_tuning_pkg::IDX_OSC_GEAR:      read_mux = {24'h00_0000, gc};
         capture_tuning_pkg::IDX_GAIN_CTRL:     read_mux = {24'h00_0000, ac}; // RULE_08
         capture_tuning_pkg::IDX_GAIN_INTERVAL: read_mux = {24'h00_0000, iv};
         capture_tuning_pkg::IDX_GAIN_STATUS:   read_mux = {24'h00_0000, st};
         capture_tuning_pkg::IDX_GAIN_VALUE:    read_mux = {24'h00_0000, gv};
         default:                               read_mux = 32'h0000_0000;
      endcase
   endfunction : read_mux

   // ==========================================================
   // Bus slave: capture address phase, write in the data phase, read data registered
   // A write lands at the end of its data phase, so a read whose address phase
   // overlaps that data phase still returns the old value
   always_comb begin
      logic take;
      logic [7:0] st;
      take        = 1'b0;
      st          = 8'h00;
      tuning_a_d  = tuning_a_q;
      tuning_b_d  = tuning_b_q;
      filt_ctrl_d = filt_ctrl_q;
      gear_ctrl_d = gear_ctrl_q;
      gain_ctrl_d = gain_ctrl_q;
      interval_d  = interval_q;
      wr_pend_d   = 1'b0;
      wr_addr_d   = wr_addr_q;
      hrdata_d    = hrdata_q;
      // Data phase of a pending write
      if (wr_pend_q) begin
         case (wr_addr_q)
            capture_tuning_pkg::IDX_TUNING_A:      tuning_a_d  = hwdata[7:0];   // RULE_01
            capture_tuning_pkg::IDX_TUNING_B:      tuning_b_d  = hwdata[7:0];   // RULE_02
            capture_tuning_pkg::IDX_SYNC_FILTER:   filt_ctrl_d = hwdata[7:0];
            capture_tuning_pkg::IDX_OSC_GEAR:      gear_ctrl_d = hwdata[7:0];
            capture_tuning_pkg::IDX_GAIN_CTRL:     gain_ctrl_d = hwdata[7:0];   // RULE_05
            capture_tuning_pkg::IDX_GAIN_INTERVAL: interval_d  = (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0];
            default:                               wr_addr_d   = wr_addr_q;
         endcase
      end
      // Address phase
      take = hsel && hready && (htrans == capture_tuning_pkg::HTRANS_NONSEQ);
      if (take) begin
         wr_addr_d = haddr[9:2];
         wr_pend_d = hwrite;
         st = {2'h0, gctl.settled, gctl.updates >= 4'(capture_tuning_pkg::SETTLE_UPDATES), gctl.updates};
         hrdata_d = hwrite ? 32'h0000_0000
                    : read_mux(haddr[9:2], tuning_a_q, tuning_b_q, filt_ctrl_q, gear_ctrl_q,
                               gain_ctrl_q, interval_q, st, gctl.gain_value);
      end
   end

   // Register bus state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tuning_a_q  <= capture_tuning_pkg::RST_TUNING_A;
         tuning_b_q  <= capture_tuning_pkg::RST_TUNING_B;
         filt_ctrl_q <= capture_tuning_pkg::RST_SYNC_FILTER;      // RULE_03
         gear_ctrl_q <= capture_tuning_pkg::RST_OSC_GEAR;
         gain_ctrl_q <= capture_tuning_pkg::RST_GAIN_CTRL;        // RULE_08
         interval_q  <= capture_tuning_pkg::RST_GAIN_INTERVAL;
         wr_pend_q   <= 1'b0;
         wr_addr_q   <= 8'h00;
         hrdata_q    <= 32'h0000_0000;
      end else if (clk_en) begin
         tuning_a_q  <= tuning_a_d;
         tuning_b_q  <= tuning_b_d;
         filt_ctrl_q <= filt_ctrl_d;
         gear_ctrl_q <= gear_ctrl_d;
         gain_ctrl_q <= gain_ctrl_d;
         interval_q  <= interval_d;
         wr_pend_q   <= wr_pend_d;
         wr_addr_q   <= wr_addr_d;
         hrdata_q    <= hrdata_d;
      end
   end

   // Zero wait states, always OKAY
   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ==========================================================
   // Pin synchronisers, two flops each
   // Both pins are asynchronous to mclk; only the second flop reads the first
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         gs_meta_q <= 1'b0;
         gs_sync_q <= 1'b0;
         gs_prev_q <= 1'b0;
         hs_meta_q <= 1'b0;
         hs_sync_q <= 1'b0;
         hs_prev_q <= 1'b0;
      end else if (clk_en) begin
         gs_meta_q <= green_channel_sync;
         gs_sync_q <= gs_meta_q;
         gs_prev_q <= gs_sync_q;
         hs_meta_q <= hsync_in;
         hs_sync_q <= hs_meta_q;
         hs_prev_q <= hs_sync_q;
      end
   end

   // ==========================================================
   // Green sync pulse filter: a high pulse passes only after FILTER_CYCLES cycles of width
   // Glitches shorter than the threshold never reach the clock loop
   always_comb begin
      pulse_cnt_d = pulse_cnt_q;
      gs_out_d    = gs_out_q;
      if (!filt_ctrl_q[capture_tuning_pkg::FILTER_EN_BIT]) begin
         pulse_cnt_d = 4'h0;
         gs_out_d    = gs_sync_q;
      end else if (!gs_sync_q) begin
         pulse_cnt_d = 4'h0;
         gs_out_d    = 1'b0;
      end else if (pulse_cnt_q < 4'(capture_tuning_pkg::FILTER_CYCLES - 1)) begin
         pulse_cnt_d = pulse_cnt_q + 4'h1;                         // RULE_03
      end else begin
         gs_out_d    = 1'b1;                                       // RULE_03
      end
   end

   // Filter state and registered outputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_cnt_q <= 4'h0;
         gs_out_q    <= 1'b0;
         gear_out_q  <= 1'b0;
         filt_out_q  <= 1'b0;
         gain_out_q  <= capture_tuning_pkg::RST_GAIN_VALUE;
      end else if (clk_en) begin
         pulse_cnt_q <= pulse_cnt_d;
         gs_out_q    <= gs_out_d;
         gear_out_q  <= gear_out_d;
         filt_out_q  <= filt_out_d;
         gain_out_q  <= gain_out_d;
      end
   end

   // Output staging
   // Pins follow their control bits one cycle later so each output leaves a flop
   always_comb begin
      gear_out_d = gear_ctrl_q[capture_tuning_pkg::GEAR_LOW_BIT];    // RULE_04
      filt_out_d = filt_ctrl_q[capture_tuning_pkg::FILTER_EN_BIT];   // RULE_03
      gain_out_d = gctl.gain_value;
   end

   assign green_sync_out             = gs_out_q;
   assign oscillator_low_range_sel   = gear_out_q;
   assign green_sync_pulse_filter_en = filt_out_q;
   assign gain_value                 = gain_out_q;

   // ==========================================================
   // Gain matching engine controls
   // Enable codes other than 110 count as off
   assign gctl.enable     = (gain_ctrl_q[capture_tuning_pkg::GAIN_EN_MSB:0]
                             == capture_tuning_pkg::GAIN_EN_ON);                 // RULE_09
   assign gctl.run        = gain_ctrl_q[capture_tuning_pkg::GAIN_HOLD_BIT];      // RULE_06 RULE_07
   assign gctl.interval   = interval_q;                                          // RULE_14
   assign gctl.hsync_edge = hs_sync_q && !hs_prev_q;

   gain_match_engine u_engine (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .clk_en      (clk_en),
      .gain_target (gain_target),
      .ctl         (gctl)
   );

endmodule : capture_tuning_config_regs

// ===== shared/capture_tuning_pkg.sv
// Package: register map, field positions, reset values and timing counts for the capture tuning registers
package capture_tuning_pkg;

   // ==========================================================
   // Register word indices; offsets are not all multiples of four, so the byte address is four times the index
   localparam logic [7:0]  IDX_TUNING_A      = 8'h2d;
   localparam logic [7:0]  IDX_TUNING_B      = 8'h2e;
   localparam logic [7:0]  IDX_SYNC_FILTER   = 8'h34;
   localparam logic [7:0]  IDX_OSC_GEAR      = 8'h36;
   localparam logic [7:0]  IDX_GAIN_CTRL     = 8'h3c;
   localparam logic [7:0]  IDX_GAIN_INTERVAL = 8'h40;
   localparam logic [7:0]  IDX_GAIN_STATUS   = 8'h41;
   localparam logic [7:0]  IDX_GAIN_VALUE    = 8'h42;

   // ==========================================================
   // Field positions
   localparam int          FILTER_EN_BIT     = 2;
   localparam int          GEAR_LOW_BIT      = 0;
   localparam int          GAIN_HOLD_BIT     = 3;
   localparam int          GAIN_EN_MSB       = 2;
   localparam int          GAIN_TEST_MSB     = 7;
   localparam int          GAIN_TEST_LSB     = 4;

   // ==========================================================
   // Encodings and reset values
   localparam logic [2:0]  GAIN_EN_OFF       = 3'h0;
   localparam logic [2:0]  GAIN_EN_ON        = 3'h6;
   localparam logic [7:0]  RST_TUNING_A      = 8'h00;
   localparam logic [7:0]  RST_TUNING_B      = 8'h00;
   localparam logic [7:0]  RST_SYNC_FILTER   = 8'h00;
   localparam logic [7:0]  RST_OSC_GEAR      = 8'h00;
   localparam logic [7:0]  RST_GAIN_CTRL     = 8'h00;
   localparam logic [7:0]  RST_GAIN_INTERVAL = 8'h40;
   localparam logic [7:0]  RST_GAIN_VALUE    = 8'h80;

   // ==========================================================
   // Timing
   localparam int          CLK_PERIOD_NS     = 40;
   localparam int          FILTER_MIN_NS     = 250;
   // Least width rounds up to whole cycles
   localparam int          FILTER_CYCLES     = (FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SETTLE_UPDATES    = 10;

   // AHB transfer encodings
   localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;

endpackage : capture_tuning_pkg

// ===== shared/gain_ctrl_if.sv
// Interface: controls and state passed between register file and gain matching engine
interface gain_ctrl_if;
   logic       enable;
   logic       run;
   logic [7:0] interval;
   logic       hsync_edge;
   logic [7:0] gain_value;
   logic [3:0] updates;
   logic       settled;

   modport regs   (output enable, output run, output interval, output hsync_edge,
                   input gain_value, input updates, input settled);
   modport engine (input enable, input run, input interval, input hsync_edge,
                   output gain_value, output updates, output settled);
endinterface : gain_ctrl_if

// ===== logic/gain_match_engine.sv
// Module: automatic gain matching engine paced by horizontal sync pulses
module gain_match_engine (
   input  wire logic   mclk,
   input  wire logic   reset_n,
   input  wire logic   clk_en,
   input  wire logic [7:0] gain_target,
   gain_ctrl_if.engine ctl
);

   logic [7:0] hs_cnt_q,  hs_cnt_d;
   logic [7:0] gain_q,    gain_d;
   logic [3:0] upd_q,     upd_d;

   // Step current gain toward target, reaching it within SETTLE_UPDATES steps from any start
   function automatic logic [7:0] gain_step(input logic [7:0] cur, input logic [7:0] tgt);
      logic [7:0] diff;
      logic [7:0] step;
      diff = (tgt > cur) ? tgt - cur : cur - tgt;
      step = (diff > 8'h1a) ? 8'h1a : diff;
      gain_step = (tgt > cur) ? cur + step : cur - step;
   endfunction : gain_step

   // Interval counting and gain update decisions
   always_comb begin
      hs_cnt_d = hs_cnt_q;
      gain_d   = gain_q;
      upd_d    = upd_q;
      if (!ctl.enable || !ctl.run) begin
         hs_cnt_d = 8'h00;                                 // RULE_07
         if (!ctl.enable) begin
            upd_d = 4'h0;
         end
      end else if (ctl.hsync_edge) begin
         if (hs_cnt_q + 8'h01 >= ctl.interval) begin
            hs_cnt_d = 8'h00;                              // RULE_14
            gain_d   = gain_step(gain_q, gain_target);     // RULE_06 RULE_11
            if (upd_q != 4'hf) begin
               upd_d = upd_q + 4'h1;
            end
         end else begin
            hs_cnt_d = hs_cnt_q + 8'h01;
         end
      end
   end

   // Register state
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         hs_cnt_q <= 8'h00;
         gain_q   <= capture_tuning_pkg::RST_GAIN_VALUE;
         upd_q    <= 4'h0;
      end else if (clk_en) begin
         hs_cnt_q <= hs_cnt_d;
         gain_q   <= gain_d;
         upd_q    <= upd_d;
      end
   end

   assign ctl.gain_value = gain_q;
   assign ctl.updates    = upd_q;
   assign ctl.settled    = (gain_q == gain_target);

endmodule : gain_match_engine

// ===== bench/capture_tuning_sva.sv
// Checker: bus response, sync filter, gear select and gain pacing of the tuning registers
module capture_tuning_sva (
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic        clk_en,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        green_channel_sync,
   input wire logic        hsync_in,
   input wire logic        green_sync_out,
   input wire logic        oscillator_low_range_sel,
   input wire logic        green_sync_pulse_filter_en,
   input wire logic [7:0]  gain_value
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // ==========================================================
   // Shadow copies of written registers and pulse age counters
   logic       wp_q, g_q, hs_q;
   logic [9:0] wa_q;
   logic [7:0] filt_q, gear_q, ctrl_q;
   logic [3:0] run_q, age_q;
   wire        acc_w = hsel && hready && htrans == capture_tuning_pkg::HTRANS_NONSEQ && clk_en;
   wire        run_w = ctrl_q[2:0] == capture_tuning_pkg::GAIN_EN_ON && ctrl_q[capture_tuning_pkg::GAIN_HOLD_BIT];

   // Track data phase writes, raw green sync run length and cycles since a line sync edge
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wp_q   <= 1'b0;
         wa_q   <= 10'h000;
         filt_q <= 8'h00;
         gear_q <= 8'h00;
         ctrl_q <= 8'h00;
         g_q    <= 1'b0;
         hs_q   <= 1'b0;
         run_q  <= 4'h0;
         age_q  <= 4'hf;
      end else begin
         wp_q <= acc_w && hwrite;
         if (acc_w) wa_q <= haddr[9:0];
         if (wp_q && wa_q == {capture_tuning_pkg::IDX_SYNC_FILTER, 2'b00}) filt_q <= hwdata[7:0];
         if (wp_q && wa_q == {capture_tuning_pkg::IDX_OSC_GEAR, 2'b00}) gear_q <= hwdata[7:0];
         if (wp_q && wa_q == {capture_tuning_pkg::IDX_GAIN_CTRL, 2'b00}) ctrl_q <= hwdata[7:0];
         g_q  <= green_channel_sync;
         hs_q <= hsync_in;
         if (green_channel_sync && !g_q) run_q <= 4'h1;
         else if (green_channel_sync && run_q != 4'hf) run_q <= run_q + 4'h1;
         if (hsync_in && !hs_q) age_q <= 4'h0;
         else if (age_q != 4'hf) age_q <= age_q + 4'h1;
      end
   end

   // ==========================================================
   // Properties
   AST_READY_HIGH: assert property (hreadyout == 1'b1)
      else $error("bus ready dropped");
   AST_RESP_OKAY: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   AST_RESET_VALUES: assert property ($past(reset_n) == 1'b0 |-> gain_value == 8'h80 &&
      !green_sync_pulse_filter_en && !oscillator_low_range_sel) else $error("wrong value after reset");
   AST_FILTER_PIN: assert property ($stable(filt_q) [*3] |->
      green_sync_pulse_filter_en == filt_q[capture_tuning_pkg::FILTER_EN_BIT]) else $error("filter pin wrong");
   AST_GEAR_PIN: assert property ($stable(gear_q) [*3] |->
      oscillator_low_range_sel == gear_q[capture_tuning_pkg::GEAR_LOW_BIT]) else $error("gear pin wrong");
   AST_SHORT_PULSE_BLOCKED: assert property ($rose(green_sync_out) && green_sync_pulse_filter_en |->
      run_q >= 4'd7) else $error("short sync pulse passed the filter");
   AST_FILTER_OFF_FOLLOWS: assert property (!green_sync_pulse_filter_en &&
      $past(green_sync_pulse_filter_en, 4) == 1'b0 |-> green_sync_out == $past(green_channel_sync, 3))
      else $error("unfiltered sync does not follow input");
   AST_GAIN_FROZEN: assert property ((!run_w) [*4] |-> $stable(gain_value))
      else $error("gain changed while held or disabled");
   AST_GAIN_PACED: assert property ($changed(gain_value) |-> age_q <= 4'd10)
      else $error("gain changed without a line sync edge");

   // Main scenarios reached
   COV_PULSE_PASSED: cover property ($rose(green_sync_out) && green_sync_pulse_filter_en);
   COV_GAIN_UPDATE: cover property (run_w && $changed(gain_value));
   COV_GEAR_LOW: cover property ($rose(oscillator_low_range_sel));
endmodule : capture_tuning_sva

bind capture_tuning_config_regs capture_tuning_sva i_capture_tuning_sva (
   .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .green_channel_sync(green_channel_sync), .hsync_in(hsync_in), .green_sync_out(green_sync_out),
   .oscillator_low_range_sel(oscillator_low_range_sel),
   .green_sync_pulse_filter_en(green_sync_pulse_filter_en), .gain_value(gain_value));

// ===== bench/testbench.sv
// Testbench: register access, sync filter, gear select and gain calibration of the tuning registers
`define CHECK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Stimulus, observed signals and register model
   logic        mclk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, green_sync = 1'b0, hsync_in = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, seed = 32'habe363d7;
   logic [7:0]  gain_value, tgt = 8'h00, held;
   logic        hreadyout, hresp, green_sync_out, gear, filt_en;
   logic        clk_en = 1'b1;
   logic [31:0] rdat;
   int          failures = 0, tests_run = 0, rises = 0;
   logic [7:0]  mdl [logic [7:0]];
   logic [7:0]  map [6] = '{capture_tuning_pkg::IDX_TUNING_A, capture_tuning_pkg::IDX_TUNING_B,
      capture_tuning_pkg::IDX_SYNC_FILTER, capture_tuning_pkg::IDX_OSC_GEAR, capture_tuning_pkg::IDX_GAIN_CTRL,
      capture_tuning_pkg::IDX_GAIN_INTERVAL};
   int          fw [4] = '{6, 7, 3, 1};
   int          fx [4] = '{0, 1, 1, 1};
   logic [7:0]  fe [4] = '{8'h04, 8'h04, 8'h00, 8'h00};

   capture_tuning_config_regs i_capture_tuning_config_regs (
      .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .green_channel_sync(green_sync), .hsync_in(hsync_in),
      .gain_target(tgt), .green_sync_out(green_sync_out), .oscillator_low_range_sel(gear),
      .green_sync_pulse_filter_en(filt_en), .gain_value(gain_value));

   // Clock and filtered pulse counter
   always #20 mclk = ~mclk;
   always @(posedge green_sync_out) rises++;

   // ==========================================================
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // One single word transfer: address phase, then data phase
   task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd, output logic [31:0] rdat);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      hwrite <= w;
      htrans <= capture_tuning_pkg::HTRANS_NONSEQ;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= {24'h0, wd};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      logic [31:0] d;
      bus(idx, 1'b1, v, d);
      if (mdl.exists(idx)) mdl[idx] = v;
   endtask : wr

   task automatic rd(input logic [7:0] idx);
      logic [31:0] d;
      bus(idx, 1'b0, 8'h00, d);
      `CHECK("register read", {24'h0, mdl.exists(idx) ? mdl[idx] : 8'h00}, d)
   endtask : rd

   task automatic init_mdl();
      foreach (map[i]) mdl[map[i]] = (i == 5) ? capture_tuning_pkg::RST_GAIN_INTERVAL : 8'h00;
   endtask : init_mdl

   // Line sync pulses, four cycles high and eight low
   task automatic hs(input int n);
      repeat (n) begin
         hsync_in <= 1'b1;
         repeat (4) @(posedge mclk);
         hsync_in <= 1'b0;
         repeat (8) @(posedge mclk);
      end
   endtask : hs

   task automatic end_sim();
      if (failures == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_sim

   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      init_mdl();
      foreach (map[i]) rd(map[i]);
      wr(8'h30, 8'h5a);
      rd(8'h30);
      wr(capture_tuning_pkg::IDX_TUNING_A, 8'he8);
      wr(capture_tuning_pkg::IDX_TUNING_B, 8'he0);
      for (int i = 2; i < 5; i++) begin
         seed = lfsr(seed);
         wr(map[i], seed[7:0] & 8'h0f);
      end
      foreach (map[i]) rd(map[i]);
      // Gear select both ways
      for (int v = 1; v >= 0; v--) begin
         wr(capture_tuning_pkg::IDX_OSC_GEAR, 8'(v));
         repeat (3) @(posedge mclk);
         `CHECK("gear select", 1'(v), gear)
      end
      // Clock enable low freezes the registers: a write then is lost
      clk_en <= 1'b0;
      bus(capture_tuning_pkg::IDX_OSC_GEAR, 1'b1, 8'h01, rdat);
      clk_en <= 1'b1;
      repeat (3) @(posedge mclk);
      `CHECK("gear frozen", 1'b0, gear)
      rd(capture_tuning_pkg::IDX_OSC_GEAR);
      // Pulse widths around the filter threshold, filter on and off
      foreach (fw[i]) begin
         wr(capture_tuning_pkg::IDX_SYNC_FILTER, fe[i]);
         repeat (4) @(posedge mclk);
         rises = 0;
         `CHECK("filter enable", fe[i][2], filt_en)
         green_sync <= 1'b1;
         repeat (fw[i]) @(posedge mclk);
         green_sync <= 1'b0;
         repeat (16) @(posedge mclk);
         `CHECK("filtered pulses", fx[i], rises)
      end
      // One-time calibration with an update every two line syncs
      seed = lfsr(seed);
      tgt <= (seed[7:0] == 8'h80) ? 8'h81 : seed[7:0];
      wr(capture_tuning_pkg::IDX_GAIN_INTERVAL, 8'h02);
      wr(capture_tuning_pkg::IDX_GAIN_CTRL, 8'h06);
      hs(4);
      `CHECK("gain held", 8'h80, gain_value)
      wr(capture_tuning_pkg::IDX_GAIN_CTRL, 8'h0e);
      hs(1);
      `CHECK("gain before interval", 8'h80, gain_value)
      hs(1);
      `CHECK("gain moved", 1'b1, gain_value !== 8'h80)
      hs(18);
      `CHECK("gain settled", tgt, gain_value)
      // Gain value and status: ten updates, settled, at target
      mdl[capture_tuning_pkg::IDX_GAIN_VALUE]  = tgt;
      mdl[capture_tuning_pkg::IDX_GAIN_STATUS] = 8'h3a;
      rd(capture_tuning_pkg::IDX_GAIN_VALUE);
      rd(capture_tuning_pkg::IDX_GAIN_STATUS);
      wr(capture_tuning_pkg::IDX_GAIN_CTRL, 8'h06);
      held = tgt;
      tgt <= ~tgt;
      hs(6);
      `CHECK("gain frozen", held, gain_value)
      wr(capture_tuning_pkg::IDX_GAIN_CTRL, 8'h08);
      hs(6);
      `CHECK("gain disabled", held, gain_value)
      // Second reset in mid-run
      reset_n <= 1'b0;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      init_mdl();
      `CHECK("gain after reset", 8'h80, gain_value)
      rd(capture_tuning_pkg::IDX_GAIN_CTRL);
      // Calibration again after reset, left updating on every line sync
      wr(capture_tuning_pkg::IDX_GAIN_INTERVAL, 8'h01);
      wr(capture_tuning_pkg::IDX_GAIN_CTRL, 8'h0e);
      hs(11);
      `CHECK("gain recalibrated", tgt, gain_value)
      end_sim();
   end

   // Watchdog far beyond the expected run length
   initial begin
      #200000;
      failures++;
      end_sim();
   end
endmodule : testbench
